// ### logic/acr_pkg.sv
/*
  Constants, field layout and carrier types of the converter configuration and
  result register block. Assumes one 200 MHz system clock and a 4-wire serial host.
*/
// Operation
// - Bit 12, reset one: zero gives straight binary, one gives offset binary.
// - Bits 11:10 reference buffers: none, negative, positive, both; reset zero.
// - Bits 9:8 input buffers, same coding, reset to both enabled.
// - Bits 5:4 reference: external, reserved, internal 2.5 V, analog supply.
// - Bits 3:0 enable the high-voltage channel and three low-voltage pairs.
// - All channel enables zero behaves as channel 0 enabled.
// - Result register is read-only, 24 bits by default, resets to zero.
// - Reading the result drives ready status bit and ready pin high.
// - Same result can be read repeatedly until a new one arrives.
// - A new conversion is not stored while the result is being read.
// - Append-status option adds the status byte, making a 32-bit read.
// - Short word option rounds results to 16 bits and shortens the read.
// - Append-status is interface register bit 6, read-write, reset zero.
// - Short word is interface bit 0; first new result afterwards is 16-bit.
package acr_pkg;

  // ==========================================================================
  // Register addresses and reset values
  localparam logic [5:0] ACR_ADDR_IFACE = 6'h02;
  localparam logic [5:0] ACR_ADDR_CFG = 6'h03;
  localparam logic [5:0] ACR_ADDR_RESULT = 6'h04;
  localparam logic [15:0] ACR_CFG_RESET = 16'h1340;
  localparam logic [15:0] ACR_CFG_WR_MASK = 16'h1f7f;
  localparam logic [23:0] ACR_RESULT_RESET = 24'h000000;

  // ==========================================================================
  // Field positions
  localparam int ACR_CODING_BIT = 12;
  localparam int ACR_REFBUF_LSB = 10;
  localparam int ACR_INBUF_LSB = 8;
  localparam int ACR_REFSEL_LSB = 4;
  localparam int ACR_CHAN_LSB = 0;
  localparam int ACR_APPEND_BIT = 6;
  localparam int ACR_SHORT_BIT = 0;
  localparam int ACR_CMD_READ_BIT = 6;
  localparam int ACR_CMD_WEN_BIT = 7;

  // ==========================================================================
  // Encodings and lengths
  localparam logic [1:0] ACR_REF_EXTERNAL = 2'h0;
  localparam logic [1:0] ACR_REF_INTERNAL = 2'h2;
  localparam logic [1:0] ACR_REF_SUPPLY = 2'h3;
  localparam logic [3:0] ACR_CHAN_DEFAULT = 4'h1;
  localparam logic [23:0] ACR_OFFSET_FLIP = 24'h800000;
  localparam logic [5:0] ACR_CMD_LEN = 6'h08;
  localparam logic [5:0] ACR_REG_LEN = 6'h10;
  localparam logic [5:0] ACR_RESULT_LEN = 6'h18;
  localparam logic [5:0] ACR_SHORT_LEN = 6'h10;
  localparam logic [5:0] ACR_STATUS_LEN = 6'h08;

  // ==========================================================================
  // Decoded converter controls
  typedef struct packed {
    logic output_coding_select;
    logic ref_buf_pos_en;
    logic ref_buf_neg_en;
    logic in_buf_pos_en;
    logic in_buf_neg_en;
    logic ref_external;
    logic ref_internal;
    logic ref_analog_supply_5v;
    logic [3:0] chan_en;
  } acr_ctrl_type;

  // Protocol states, one-hot
  typedef enum logic [3:0] {
    ACR_ST_IDLE = 4'b0001,
    ACR_ST_CMD = 4'b0010,
    ACR_ST_WR = 4'b0100,
    ACR_ST_RD = 4'b1000
  } acr_state_type;

endpackage

// ### logic/acr_serial_port.sv
/*
  Pin synchroniser of the 4-wire serial port: brings clock, select and data into
  the system clock domain and marks rising serial clock edges.
  Assumes the serial clock is well below a quarter of the system clock.
*/
`timescale 1ns/1ps
module acr_serial_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic sclk_rise,
  output logic bit_in,
  output logic active
);
  import acr_pkg::*;

  logic [2:0] sync1_q, sync1_d;
  logic [2:0] sync2_q, sync2_d;
  logic sclk_last_q, sclk_last_d;

  // ==========================================================================
  // Two flops per pin; the first stage feeds only the second
  always_comb begin
    sync1_d = {sclk, cs_n, din};
    sync2_d = sync1_q;
    sclk_last_d = sync2_q[2];
  end

  // Flops reset to the idle pin levels, so no false clock edge follows reset

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 3'h6;
      sync2_q <= 3'h6;
      sclk_last_q <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sclk_last_q <= sclk_last_d;
    end
  end

  // Edge seen only while selected, so idle clock toggles are harmless
  assign sclk_rise = sync2_q[2] & ~sclk_last_q & ~sync2_q[1];
  assign bit_in = sync2_q[0];
  assign active = ~sync2_q[1];

endmodule

// ### logic/acr_config_result_regs.sv
/*
  Configuration and conversion result registers behind the 4-wire serial port.
  Assumes conversions arrive as one-cycle pulses of two's complement words on
  the system clock, and the low seven status bits come from the status register outside.
*/
`timescale 1ns/1ps
module acr_config_result_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy,
  output logic dout_oe,
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic [6:0] status_low,
  output acr_pkg::acr_ctrl_type ctrl,
  output logic append_status,
  output logic short_word_select,
  output logic ready_n
);
  import acr_pkg::*;

  logic sclk_rise, bit_in, active;
  acr_state_type state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] cmd_q, cmd_d;
  logic [15:0] wdata_q, wdata_d;
  logic [31:0] shreg_q, shreg_d;
  logic [5:0] rd_len_q, rd_len_d;
  logic result_busy_q, result_busy_d;
  logic [15:0] cfg_q, cfg_d;
  logic append_q, append_d;
  logic short_q, short_d;
  logic [23:0] result_q, result_d;
  logic ready_n_q, ready_n_d;
  logic dout_q, dout_d;
  acr_ctrl_type ctrl_q, ctrl_d;
  logic [7:0] cmd_next;
  logic [15:0] wdata_next;
  logic [5:0] addr;
  logic store_en;
  logic read_start;
  logic [23:0] coded;
  logic [16:0] rounded;

  acr_serial_port u_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .sclk_rise(sclk_rise),
    .bit_in(bit_in),
    .active(active)
  );

  assign cmd_next = {cmd_q[6:0], bit_in};
  assign wdata_next = {wdata_q[14:0], bit_in};
  assign addr = cmd_next[5:0];

  // ==========================================================================
  // Conversion coding, rounding and store
  always_comb begin
    if (cfg_q[ACR_CODING_BIT]) begin
      coded = conv_data ^ ACR_OFFSET_FLIP;
    end else if (conv_data[23]) begin
      coded = 24'h000000; // Negative input clips to zero in straight binary
    end else begin
      coded = {conv_data[22:0], 1'b0};
    end
    // Round half up, saturating at full scale
    rounded = {1'b0, coded[23:8]} + {16'h0000, coded[7]};
    if (rounded[16]) begin
      rounded = 17'h0ffff;
    end
  end

  // Rounding is taken at store time, but the read length follows short_q at read start
  // A read that starts in the store cycle wins, so the word sent is the one kept
  assign read_start = (state_q == ACR_ST_CMD) & sclk_rise & (cnt_q == ACR_CMD_LEN - 6'h01) &
    ~cmd_next[ACR_CMD_WEN_BIT] & cmd_next[ACR_CMD_READ_BIT] & (addr == ACR_ADDR_RESULT);
  assign store_en = conv_valid & ~result_busy_q & ~read_start;

  always_comb begin
    result_d = result_q; // Held for repeated reads
    if (store_en && short_q) begin
      result_d = {rounded[15:0], 8'h00};
    end else if (store_en) begin
      result_d = coded;
    end
  end

  // ==========================================================================
  // Serial protocol: command byte, then 16 write bits or the read word
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cmd_d = cmd_q;
    wdata_d = wdata_q;
    shreg_d = shreg_q;
    rd_len_d = rd_len_q;
    result_busy_d = result_busy_q;
    cfg_d = cfg_q;
    append_d = append_q;
    short_d = short_q;
    ready_n_d = ready_n_q;
    // A new result marks ready; a read start in the same cycle blocks the store
    if (store_en) begin
      ready_n_d = 1'b0;
    end
    case (state_q)
      ACR_ST_IDLE: begin
        cnt_d = 6'h00;
        if (active) begin
          state_d = ACR_ST_CMD;
        end
      end
      ACR_ST_CMD: begin
        if (sclk_rise) begin
          cmd_d = cmd_next;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == ACR_CMD_LEN - 6'h01) begin
            cnt_d = 6'h00;
            if (cmd_next[ACR_CMD_WEN_BIT]) begin
              state_d = ACR_ST_CMD; // Disabled command byte is ignored
            end else if (!cmd_next[ACR_CMD_READ_BIT]) begin
              state_d = ACR_ST_WR;
            end else begin
              state_d = ACR_ST_RD;
              rd_len_d = ACR_REG_LEN;
              shreg_d = 32'h00000000;
              if (addr == ACR_ADDR_IFACE) begin
                shreg_d[31:16] = {9'h000, append_q, 5'h00, short_q};
              end else if (addr == ACR_ADDR_CFG) begin
                shreg_d[31:16] = cfg_q;
              end else if (addr == ACR_ADDR_RESULT) begin
                result_busy_d = 1'b1;
                ready_n_d = 1'b1;
                rd_len_d = short_q ? ACR_SHORT_LEN : ACR_RESULT_LEN;
                if (append_q) begin
                  rd_len_d = rd_len_d + ACR_STATUS_LEN;
                end
                if (short_q) begin
                  shreg_d = {result_q[23:8], ready_n_q, status_low, 8'h00};
                end else begin
                  shreg_d = {result_q, ready_n_q, status_low};
                end
              end
            end
          end
        end
      end
      ACR_ST_WR: begin
        if (sclk_rise) begin
          wdata_d = wdata_next;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == ACR_REG_LEN - 6'h01) begin
            cnt_d = 6'h00;
            state_d = ACR_ST_CMD;
            // Result register is read-only; unmapped writes are dropped
            if (cmd_q[5:0] == ACR_ADDR_CFG) begin
              cfg_d = wdata_next & ACR_CFG_WR_MASK; // Reserved bits stay zero
            end else if (cmd_q[5:0] == ACR_ADDR_IFACE) begin
              append_d = wdata_next[ACR_APPEND_BIT];
              short_d = wdata_next[ACR_SHORT_BIT];
            end
          end
        end
      end
      ACR_ST_RD: begin
        if (sclk_rise) begin
          shreg_d = {shreg_q[30:0], 1'b0};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == rd_len_q - 6'h01) begin
            cnt_d = 6'h00;
            state_d = ACR_ST_CMD;
            result_busy_d = 1'b0;
          end
        end
      end
      default: begin
        state_d = ACR_ST_IDLE;
      end
    endcase
    // Deselect aborts any transfer and frees the result register
    if (!active) begin
      state_d = ACR_ST_IDLE;
      result_busy_d = 1'b0;
    end
  end

  // ==========================================================================
  // Decoded controls, registered so every output comes from a flop
  always_comb begin
    ctrl_d.output_coding_select = cfg_q[ACR_CODING_BIT];
    ctrl_d.ref_buf_pos_en = cfg_q[ACR_REFBUF_LSB + 1];
    ctrl_d.ref_buf_neg_en = cfg_q[ACR_REFBUF_LSB];
    ctrl_d.in_buf_pos_en = cfg_q[ACR_INBUF_LSB + 1];
    ctrl_d.in_buf_neg_en = cfg_q[ACR_INBUF_LSB];
    // Reserved source code selects nothing
    ctrl_d.ref_external = cfg_q[ACR_REFSEL_LSB +: 2] == ACR_REF_EXTERNAL;
    ctrl_d.ref_internal = cfg_q[ACR_REFSEL_LSB +: 2] == ACR_REF_INTERNAL;
    ctrl_d.ref_analog_supply_5v = cfg_q[ACR_REFSEL_LSB +: 2] == ACR_REF_SUPPLY;
    ctrl_d.chan_en = cfg_q[ACR_CHAN_LSB +: 4];
    if (cfg_q[ACR_CHAN_LSB +: 4] == 4'h0) begin
      ctrl_d.chan_en = ACR_CHAN_DEFAULT;
    end
    // Pin shows ready outside the read data bits and the read word during them
    dout_d = (state_q == ACR_ST_RD) ? shreg_q[31] : ready_n_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ACR_ST_IDLE;
      cnt_q <= 6'h00;
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
      shreg_q <= 32'h00000000;
      rd_len_q <= ACR_REG_LEN;
      result_busy_q <= 1'b0;
      cfg_q <= ACR_CFG_RESET;
      append_q <= 1'b0;
      short_q <= 1'b0;
      result_q <= ACR_RESULT_RESET;
      ready_n_q <= 1'b1;
      dout_q <= 1'b1;
      ctrl_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      wdata_q <= wdata_d;
      shreg_q <= shreg_d;
      rd_len_q <= rd_len_d;
      result_busy_q <= result_busy_d;
      cfg_q <= cfg_d;
      append_q <= append_d;
      short_q <= short_d;
      result_q <= result_d;
      ready_n_q <= ready_n_d;
      dout_q <= dout_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;
  assign append_status = append_q;
  assign short_word_select = short_q;
  assign ready_n = ready_n_q;
  assign dout_rdy = dout_q;
  assign dout_oe = active;

  // ==========================================================================
  // Checks
  a_chan_default: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_q[3:0] == 4'h0) |=> (ctrl.chan_en == 4'h1)) else $error("empty channel set not defaulted");
  a_chan_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cfg_q[3:0] != 4'h0) ##1 $stable(cfg_q) |-> (ctrl.chan_en == cfg_q[3:0])) else $error("channel enables wrong");
  a_read_marks_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(result_busy_q) |-> ready_n_q) else $error("result read left ready low");
  a_pin_shows_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_q != ACR_ST_RD) |=> (dout_rdy == $past(ready_n_q))) else $error("ready pin differs from ready bit");
  a_store_held_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (result_busy_q && conv_valid) |=> $stable(result_q)) else $error("result changed during read");
  a_result_repeat: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !conv_valid |=> $stable(result_q)) else $error("result changed without conversion");
  a_new_result_rdy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    store_en |=> !ready_n_q) else $error("new result not flagged ready");
  a_short_round: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (store_en && short_q) |=> (result_q[7:0] == 8'h00)) else $error("short result not rounded");
  a_bipolar_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (store_en && !short_q && cfg_q[12] && conv_data == 24'h000000) |=> (result_q == 24'h800000))
    else $error("offset binary coding wrong");
  a_append_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(result_busy_q) && $past(append_q) && !$past(short_q) |-> (rd_len_q == 6'h20)) else $error("append read not 32 bits");
  a_ref_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $stable(cfg_q) && (cfg_q[5:4] == 2'h2) |-> ctrl.ref_internal && !ctrl.ref_external) else $error("reference select wrong");

endmodule

// ### verification/acr_host_model.sv
/*
  Host controller model of the 4-wire serial port: frames a command byte, then
  16 write bits or a given number of read bits. Assumes the caller runs on the
  falling edge of the system clock; the serial clock idles high between frames.
*/
`timescale 1ns/1ps
module acr_host_model (
  input wire logic sys_clk,
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_rdy
);
  // Half serial period in system clocks, four times the synchroniser minimum
  localparam int HALF = 8;

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // ==========================================================================
  // One bit: data set on the falling edge, read bit taken just before the rise
  task automatic bit_io(input logic b, output logic r);
    sclk = 1'b0;
    din = b;
    repeat (HALF) @(negedge sys_clk);
    r = dout_rdy;
    sclk = 1'b1;
    repeat (HALF) @(negedge sys_clk);
  endtask

  // ==========================================================================
  // Whole frame; select is dropped at the end so no transfer is left open
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nrd, output logic [31:0] rd);
    logic r;
    rd = '0;
    cs_n = 1'b0;
    repeat (HALF) @(negedge sys_clk);
    for (int i = 7; i >= 0; i--) bit_io(cmd[i], r);
    if (!cmd[6]) begin
      for (int i = 15; i >= 0; i--) bit_io(wd[i], r);
    end else begin
      // Data line toggles while unused, so no stale level can pass
      for (int i = 0; i < nrd; i++) begin
        bit_io(~din, r);
        rd = {rd[30:0], r};
      end
    end
    cs_n = 1'b1;
    din = ~din;
    repeat (4 * HALF) @(negedge sys_clk);
  endtask
endmodule

// ### verification/acr_config_result_regs_tb.sv
/*
  Self-checking testbench of the configuration and result registers.
  Assumes the host model for the serial pins; conversions are driven here.
*/
`timescale 1ns/1ps
module acr_config_result_regs_tb;
  import acr_pkg::*;
  logic sys_clk, rst_n, sclk, cs_n, din, dout_rdy, dout_oe, conv_valid;
  logic append_status, short_word_select, ready_n;
  logic [23:0] conv_data;
  logic [6:0] status_low;
  acr_ctrl_type ctrl;
  int fail_count, num_checks;
  logic [31:0] rd;
  logic [15:0] cfg;
  logic [1:0] sel_tab [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [3:0] chan_tab [4] = '{4'h0, 4'h1, 4'h6, 4'hf};

  acr_config_result_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy(dout_rdy), .dout_oe(dout_oe), .conv_valid(conv_valid), .conv_data(conv_data),
    .status_low(status_low), .ctrl(ctrl), .append_status(append_status),
    .short_word_select(short_word_select), .ready_n(ready_n));
  acr_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy(dout_rdy));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Compare and report
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected decode worked out from the configuration word
  task automatic check_ctrl(input logic [15:0] c);
    acr_ctrl_type e;
    e = '{c[12], c[11], c[10], c[9], c[8], c[5:4] == 2'h0, c[5:4] == 2'h2, c[5:4] == 2'h3,
      (c[3:0] == 4'h0) ? 4'h1 : c[3:0]};
    check_word({20'h0, ctrl}, {20'h0, e});
  endtask

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Register access and conversion tasks
  task automatic reg_rd(input logic [5:0] a, input int n);
    host.xfer({2'b01, a}, 16'h0, n, rd);
  endtask

  task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({2'b00, a}, d, 0, rd);
  endtask

  task automatic pulse(input logic [23:0] d);
    conv_valid = 1'b1;
    conv_data = d;
    @(negedge sys_clk);
    conv_valid = 1'b0;
  endtask

  // Bounded wait for the ready flag, a hang ends the run
  task automatic convert(input logic [23:0] d);
    int n;
    pulse(d);
    n = 0;
    while (ready_n !== 1'b0 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 10) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, ready_n, 1'b0);
      complete_run();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    conv_valid = 1'b0;
    conv_data = 24'h000000;
    status_low = 7'h5a;
    fail_count = 0;
    num_checks = 0;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check_ctrl(ACR_CFG_RESET);
    check_word({31'h0, ready_n}, 32'h1);
    check_word({31'h0, dout_oe}, 32'h0);
    reg_rd(ACR_ADDR_CFG, 16);
    check_word(rd, {16'h0, ACR_CFG_RESET});
    reg_rd(ACR_ADDR_RESULT, 24);
    check_word(rd, 32'h0);
    reg_rd(ACR_ADDR_IFACE, 16);
    check_word(rd, 32'h0);
    $display("Test reset values done");

    // Mode register lives outside, so this address reads as unmapped
    reg_wr(6'h01, 16'h8000);
    reg_rd(6'h01, 16);
    check_word(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      cfg = {3'h0, i[0], i[1:0], 2'(3 - i), 2'b01, sel_tab[i], chan_tab[i]};
      reg_wr(ACR_ADDR_CFG, cfg);
      check_ctrl(cfg);
      reg_rd(ACR_ADDR_CFG, 16);
      check_word(rd, {16'h0, cfg});
    end
    $display("Test configuration fields done");

    reg_wr(ACR_ADDR_CFG, 16'h1f41);
    convert(24'h123456);
    for (int k = 0; k < 2; k++) begin
      reg_rd(ACR_ADDR_RESULT, 24);
      check_word(rd, 32'h923456);
      check_word({30'h0, ready_n, dout_rdy}, 32'h3);
    end
    // A conversion lands in the middle of the data bits
    fork
      reg_rd(ACR_ADDR_RESULT, 24);
      begin
        repeat (300) @(negedge sys_clk);
        check_word({31'h0, dout_oe}, 32'h1);
        pulse(24'h000001);
      end
    join
    check_word(rd, 32'h923456);
    check_word({31'h0, ready_n}, 32'h1);
    reg_rd(ACR_ADDR_RESULT, 24);
    check_word(rd, 32'h923456);
    convert(24'h000000);
    reg_rd(ACR_ADDR_RESULT, 24);
    check_word(rd, 32'h800000);
    reg_wr(ACR_ADDR_CFG, 16'h0f41);
    convert(24'h800001);
    reg_rd(ACR_ADDR_RESULT, 24);
    check_word(rd, 32'h0);
    convert(24'h123456);
    reg_rd(ACR_ADDR_RESULT, 24);
    check_word(rd, 32'h2468ac);
    $display("Test result reads done");

    reg_wr(ACR_ADDR_IFACE, 16'h0040);
    reg_rd(ACR_ADDR_IFACE, 16);
    check_word(rd, 32'h40);
    check_word({31'h0, append_status}, 32'h1);
    convert(24'h654321);
    reg_rd(ACR_ADDR_RESULT, 32);
    // Appended byte carries the ready bit, still low before this read, then status
    check_word(rd, {24'hca8642, 1'b0, status_low});
    $display("Test appended status done");

    reg_wr(ACR_ADDR_IFACE, 16'h0001);
    reg_wr(ACR_ADDR_CFG, 16'h1f41);
    check_word({31'h0, short_word_select}, 32'h1);
    reg_rd(ACR_ADDR_RESULT, 16);
    check_word(rd, 32'hca86);
    convert(24'h123480);
    reg_rd(ACR_ADDR_RESULT, 16);
    check_word(rd, 32'h9235);
    convert(24'h7fffff);
    reg_rd(ACR_ADDR_RESULT, 16);
    check_word(rd, 32'hffff);
    $display("Test short word done");
    complete_run();
  end
endmodule
